// ---- hdl/dcd_pkg.sv ----
// Shared constants and types of the command decoder
// Notes on behaviour
// - Commands decode from CS, RAS, CAS, WE, CKE sampled at the clock edge.
// - Present state is that before the edge; CKE now vs before picks moves.
// - CKE low twice holds power-down or self refresh; low-high with DES/NOP exits.
// - High-low with DES/NOP: active, plain or precharge power-down by activity.
// - REFRESH with CKE falling while all banks idle enters self refresh.
// - ODT plays no part in power-state choice.
// - Fully idle: banks closed, no burst, CKE high, every timer expired.
// - Deselect starts nothing and leaves running work alone.
// - NOP registers nothing and leaves running work alone.
// - Long calibration runs the engine, then updates drive and termination.
// - Short calibration completes within 64 clock cycles.
// - ACTIVATE opens the row in the addressed bank until precharged.
// - READ starts a burst from an open row at the given column.
// - A10 high on READ closes the row when the burst ends.
// - With per-command selection, A12 picks eight beats or a chop.
// - A started read burst runs to its end, never cut short.
// - READ is CS low, RAS high, CAS low, WE high.
package dcd_pkg;

    localparam int CLK_PS   = 5000;
    localparam int T_RP_NS  = 15;
    localparam int T_RFC_NS = 160;
    localparam int T_XP_NS  = 6;
    localparam int TMR_W    = 10;
    // Least times, rounded up to whole cycles
    localparam logic [TMR_W-1:0] RP_CYC  =
        TMR_W'((T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TMR_W-1:0] RFC_CYC =
        TMR_W'((T_RFC_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TMR_W-1:0] XP_CYC  =
        TMR_W'((T_XP_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TMR_W-1:0] ZQ_INIT_CYC  = 10'h200;
    localparam logic [TMR_W-1:0] ZQ_OPER_CYC  = 10'h100;
    localparam logic [TMR_W-1:0] ZQ_SHORT_CYC = 10'h040;
    localparam logic [2:0] BURST8_CYC = 3'h4;
    localparam logic [2:0] CHOP_CYC   = 3'h2;
    localparam int BANKS  = 8;
    localparam int BA_W   = 3;
    localparam int ADDR_W = 16;
    localparam int COL_W  = 10;
    localparam int A10_BIT = 10;
    localparam int A12_BIT = 12;
    localparam int RDQ_W  = BA_W + COL_W + 2;
    localparam int PIN_W  = 5 + BA_W + ADDR_W;

    typedef enum logic [2:0] {
        PS_ON     = 3'b000,
        PS_PD_ACT = 3'b001,
        PS_PD_PRE = 3'b010,
        PS_PD     = 3'b011,
        PS_SREF   = 3'b100
    } dcd_pstate_t;

    typedef enum logic [2:0] {
        CMD_DES = 3'b000,
        CMD_NOP = 3'b001,
        CMD_ACT = 3'b010,
        CMD_RD  = 3'b011,
        CMD_PRE = 3'b100,
        CMD_REF = 3'b101,
        CMD_ZQ  = 3'b110,
        CMD_OTH = 3'b111
    } dcd_cmd_t;
endpackage : dcd_pkg

// ---- hdl/dcd_pair_buf.sv ----
// Two-entry valid/ready buffer for decoded read commands
`timescale 1ns/100ps
module dcd_pair_buf #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_r [2];
    logic         wp_r;
    logic         rp_r;
    logic [1:0]   cnt_r;
    logic         push;
    logic         pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) wp_r <= ~wp_r;
            if (pop) rp_r <= ~rp_r;
            if (push && !pop) cnt_r <= cnt_r + 2'h1;
            else if (pop && !push) cnt_r <= cnt_r - 2'h1;
        end
    end

    a_buf_no_over: assert property (@(posedge clk) disable iff (reset)
        cnt_r == 2'h2 && !pop |=> cnt_r == 2'h2)
        else $error("buffer lost an entry");
endmodule : dcd_pair_buf

// ---- hdl/dcd_cmd_decode.sv ----
// Clock-enable power states and command decode of the memory device
`timescale 1ns/100ps
module dcd_cmd_decode (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Command and address pins
    input  wire logic                       cke,
    input  wire logic                       cs_n,
    input  wire logic                       ras_n,
    input  wire logic                       cas_n,
    input  wire logic                       we_n,
    input  wire logic [dcd_pkg::BA_W-1:0]   ba,
    input  wire logic [dcd_pkg::ADDR_W-1:0] addr,
    // Mode settings
    input  wire logic                       mr_otf_en,
    input  wire logic                       mr_fixed_bc4,
    input  wire logic                       init_done,
    // Read command stream
    output logic                            rd_valid,
    input  wire logic                       rd_ready,
    output logic [dcd_pkg::BA_W-1:0]        rd_bank,
    output logic [dcd_pkg::COL_W-1:0]       rd_col,
    output logic                            rd_len8,
    output logic                            rd_auto_close,
    // Status
    output dcd_pkg::dcd_pstate_t            pwr_state,
    output logic [dcd_pkg::BANKS-1:0]       bank_open,
    output logic                            fully_idle,
    output logic                            burst_busy,
    output logic                            zq_busy,
    output logic                            zq_update,
    output logic                            cmd_ignored
);
    import dcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [PIN_W-1:0]  pin_s1_r;
    logic [PIN_W-1:0]  pin_s2_r;
    logic              cke_now;
    logic              cke_prev_r;
    logic              cs_now_n;
    logic [2:0]        rcw;
    logic [BA_W-1:0]   ba_now;
    logic [ADDR_W-1:0] a_now;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign {cke_now, cs_now_n, rcw, ba_now, a_now} = pin_s2_r;

    // CKE at the previous edge
    always_ff @(posedge clk) begin
        if (reset) cke_prev_r <= 1'b0;
        else cke_prev_r <= cke_now;
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    dcd_cmd_t cmd;
    logic     desnop;
    logic     entry;
    logic     exit_ev;
    logic     exec;

    always_comb begin
        if (cs_now_n) begin
            cmd = CMD_DES;
        end else begin
            case (rcw)
                3'b111:  cmd = CMD_NOP;
                3'b011:  cmd = CMD_ACT;
                3'b101:  cmd = CMD_RD;
                3'b010:  cmd = CMD_PRE;
                3'b001:  cmd = CMD_REF;
                3'b110:  cmd = CMD_ZQ;
                default: cmd = CMD_OTH;
            endcase
        end
    end

    assign desnop  = (cmd == CMD_DES) || (cmd == CMD_NOP);
    assign entry   = cke_prev_r && !cke_now;
    assign exit_ev = !cke_prev_r && cke_now;

    dcd_pstate_t      pstate_r;
    logic [BANKS-1:0] bank_open_r;
    logic [2:0]       burst_cnt_r;
    logic [BA_W-1:0]  burst_bank_r;
    logic             burst_auto_r;
    logic [TMR_W-1:0] pre_cnt_r;
    logic [TMR_W-1:0] ref_cnt_r;
    logic [TMR_W-1:0] zq_cnt_r;
    logic [TMR_W-1:0] xp_cnt_r;
    logic             zq_update_r;
    logic             ignored_r;
    logic             buf_in_ready;
    logic             rd_take;
    logic             len8;
    logic             burst_end;
    logic             zq_take;
    logic             ref_take;

    // Commands run only when powered up with CKE high at both edges
    assign exec = (pstate_r == PS_ON) && cke_prev_r && cke_now;

    // Idle apart from CKE; self refresh entry sees CKE already falling
    logic             banks_quiet;
    assign banks_quiet = (bank_open_r == '0) && (burst_cnt_r == 3'h0) &&
                         (pre_cnt_r == '0) && (ref_cnt_r == '0) &&
                         (zq_cnt_r == '0) && (xp_cnt_r == '0);
    assign fully_idle  = banks_quiet && cke_now;

    ////////////////////////////////////////////////////////////////////////
    // Power state; ODT has no input here by design
    always_ff @(posedge clk) begin
        if (reset) begin
            pstate_r <= PS_ON;
        end else begin
            case (pstate_r)
                PS_ON: begin
                    if (entry && cmd == CMD_REF && banks_quiet) begin
                        pstate_r <= PS_SREF;
                    end else if (entry && desnop) begin
                        // Burst implies an open bank, so it ranks first
                        if (burst_cnt_r != 3'h0 || pre_cnt_r != '0)
                            pstate_r <= PS_PD;
                        else if (bank_open_r != '0)
                            pstate_r <= PS_PD_ACT;
                        else
                            pstate_r <= PS_PD_PRE;
                    end
                end
                PS_PD_ACT, PS_PD_PRE, PS_PD, PS_SREF: begin
                    if (exit_ev && desnop) pstate_r <= PS_ON;
                end
                default: pstate_r <= PS_ON;
            endcase
        end
    end

    // Exit delay holds off fully idle after wake-up
    always_ff @(posedge clk) begin
        if (reset) xp_cnt_r <= '0;
        else if (pstate_r != PS_ON && exit_ev && desnop) xp_cnt_r <= XP_CYC;
        else if (xp_cnt_r != '0) xp_cnt_r <= xp_cnt_r - 10'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read acceptance; a full buffer refuses the read
    assign len8 = mr_otf_en ? a_now[A12_BIT] : !mr_fixed_bc4;
    assign rd_take = exec && cmd == CMD_RD && bank_open_r[ba_now] &&
                     burst_cnt_r == 3'h0 && buf_in_ready;
    assign burst_end = (burst_cnt_r == 3'h1);
    assign zq_take  = exec && cmd == CMD_ZQ && zq_cnt_r == '0;
    assign ref_take = exec && cmd == CMD_REF && bank_open_r == '0;

    // Burst counter never reloads mid-burst
    always_ff @(posedge clk) begin
        if (reset) begin
            burst_cnt_r  <= 3'h0;
            burst_bank_r <= '0;
            burst_auto_r <= 1'b0;
        end else if (rd_take) begin
            burst_cnt_r  <= len8 ? BURST8_CYC : CHOP_CYC;
            burst_bank_r <= ba_now;
            burst_auto_r <= a_now[A10_BIT];
        end else if (burst_cnt_r != 3'h0) begin
            burst_cnt_r <= burst_cnt_r - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bank open record
    genvar gb;
    generate
        for (gb = 0; gb < BANKS; gb++) begin : g_bank
            always_ff @(posedge clk) begin
                if (reset) begin
                    bank_open_r[gb] <= 1'b0;
                end else if (exec && cmd == CMD_ACT &&
                             ba_now == BA_W'(gb)) begin
                    bank_open_r[gb] <= 1'b1;
                end else if (exec && cmd == CMD_PRE &&
                             (a_now[A10_BIT] || ba_now == BA_W'(gb))) begin
                    bank_open_r[gb] <= 1'b0;
                end else if (burst_end && burst_auto_r &&
                             burst_bank_r == BA_W'(gb)) begin
                    bank_open_r[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    // Precharge and refresh busy windows
    always_ff @(posedge clk) begin
        if (reset) pre_cnt_r <= '0;
        else if ((exec && cmd == CMD_PRE) || (burst_end && burst_auto_r))
            pre_cnt_r <= RP_CYC;
        else if (pre_cnt_r != '0) pre_cnt_r <= pre_cnt_r - 10'h001;
    end

    always_ff @(posedge clk) begin
        if (reset) ref_cnt_r <= '0;
        else if (ref_take) ref_cnt_r <= RFC_CYC;
        else if (ref_cnt_r != '0) ref_cnt_r <= ref_cnt_r - 10'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Impedance calibration engine
    always_ff @(posedge clk) begin
        if (reset) begin
            zq_cnt_r <= '0;
        end else if (zq_take) begin
            if (!a_now[A10_BIT])
                zq_cnt_r <= ZQ_SHORT_CYC;
            else
                zq_cnt_r <= init_done ? ZQ_OPER_CYC : ZQ_INIT_CYC;
        end else if (zq_cnt_r != '0) begin
            zq_cnt_r <= zq_cnt_r - 10'h001;
        end
    end

    // Results move to the drivers as the window closes
    always_ff @(posedge clk) begin
        if (reset) zq_update_r <= 1'b0;
        else zq_update_r <= (zq_cnt_r == 10'h001);
    end

    // Flags a command that was decoded but not carried out
    always_ff @(posedge clk) begin
        if (reset) begin
            ignored_r <= 1'b0;
        end else begin
            ignored_r <= exec && !desnop && !rd_take && !zq_take &&
                         !ref_take && !(cmd == CMD_ACT) &&
                         !(cmd == CMD_PRE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read stream buffer
    dcd_pair_buf #(
        .W (RDQ_W)
    ) dcd_pair_buf_i (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (rd_take),
        .in_ready  (buf_in_ready),
        .in_data   ({ba_now, a_now[COL_W-1:0], len8, a_now[A10_BIT]}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  ({rd_bank, rd_col, rd_len8, rd_auto_close})
    );

    assign pwr_state   = pstate_r;
    assign bank_open   = bank_open_r;
    assign burst_busy  = (burst_cnt_r != 3'h0);
    assign zq_busy     = (zq_cnt_r != '0);
    assign zq_update   = zq_update_r;
    assign cmd_ignored = ignored_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_sref_entry: assert property (
        pstate_r == PS_ON && entry && cmd == CMD_REF && banks_quiet
        |=> pstate_r == PS_SREF)
        else $error("self refresh not entered");

    a_rd_refused: assert property (
        exec && cmd == CMD_RD && !bank_open_r[ba_now] |=> ignored_r)
        else $error("read to closed bank not refused");

    a_nop_quiet: assert property (
        desnop && !burst_end |=> bank_open_r == $past(bank_open_r))
        else $error("idle command changed a bank");

    a_pd_active: assert property (
        pstate_r == PS_ON && entry && desnop && burst_cnt_r == 3'h0 &&
        pre_cnt_r == '0 && bank_open_r != '0 |=> pstate_r == PS_PD_ACT)
        else $error("active power-down not entered");

    a_zql_window: assert property (
        zq_take && a_now[A10_BIT] && init_done |-> ##257 zq_update_r)
        else $error("long calibration late");

    a_pre_closes: assert property (
        exec && cmd == CMD_PRE && a_now[A10_BIT] |=> bank_open_r == '0)
        else $error("precharge all left a bank open");

    a_pd_hold: assert property (
        pstate_r != PS_ON && !cke_prev_r && !cke_now
        |=> pstate_r == $past(pstate_r))
        else $error("power-down left with CKE low");

    a_pd_exit: assert property (
        pstate_r != PS_ON && exit_ev && desnop |=> pstate_r == PS_ON)
        else $error("power-down exit missed");

    a_pd_kind: assert property (
        pstate_r == PS_ON && entry && desnop && burst_cnt_r != 3'h0
        |=> pstate_r == PS_PD)
        else $error("wrong power-down kind while reading");

    a_act_opens: assert property (
        exec && cmd == CMD_ACT |=> bank_open_r[$past(ba_now)])
        else $error("activate did not open bank");

    a_burst_runs: assert property (
        rd_take && len8 |=> burst_cnt_r == 3'h4 ##1 burst_cnt_r == 3'h3
        ##1 burst_cnt_r == 3'h2 ##1 burst_cnt_r == 3'h1)
        else $error("burst cut short");

    a_auto_close: assert property (
        burst_end && burst_auto_r && !(exec && cmd == CMD_ACT)
        |=> !bank_open_r[$past(burst_bank_r)])
        else $error("auto close missed");

    a_zqs_window: assert property (
        zq_take && !a_now[A10_BIT] |-> ##65 zq_update_r)
        else $error("short calibration late");

    a_des_keeps: assert property (
        burst_cnt_r > 3'h1 && cmd == CMD_DES
        |=> burst_cnt_r == $past(burst_cnt_r) - 3'h1)
        else $error("deselect disturbed burst");

    c_sref: cover property (pstate_r == PS_ON ##1 pstate_r == PS_SREF);
    c_rd_auto: cover property (burst_end && burst_auto_r);
    c_zq_long: cover property (zq_take && a_now[A10_BIT]);
    c_pd_act: cover property (pstate_r == PS_PD_ACT ##1 pstate_r == PS_ON);
endmodule : dcd_cmd_decode

// ---- tb/dcd_ctrl_model.sv ----
// Memory controller model driving command, address and clock enable
`timescale 1ns/100ps
module dcd_ctrl_model (
    // Clock
    input  wire logic                   clk,
    // Command and address pins
    output logic                        cke,
    output logic                        cs_n,
    output logic                        ras_n,
    output logic                        cas_n,
    output logic                        we_n,
    output logic [dcd_pkg::BA_W-1:0]    ba,
    output logic [dcd_pkg::ADDR_W-1:0]  addr
);
    import dcd_pkg::*;

    initial begin
        cke = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        ba = '0;
        addr = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins for one edge; only defined encodings are ever issued
    task automatic drive(input logic c, input logic [2:0] rcw,
                         input logic k, input logic [BA_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        cke <= k;
        cs_n <= c;
        {ras_n, cas_n, we_n} <= rcw;
        ba <= b;
        addr <= a;
    endtask : drive

    // Command for one cycle, then a NOP that keeps cke
    task automatic send(input logic [2:0] rcw, input logic k,
                        input logic [BA_W-1:0] b,
                        input logic [ADDR_W-1:0] a);
        @(posedge clk);
        drive(1'b0, rcw, k, b, a);
        @(posedge clk);
        drive(1'b0, 3'h7, k, BA_W'($urandom), ADDR_W'($urandom));
    endtask : send

    // Idle edges; under DES the other pins mean nothing, so scramble them
    task automatic idle(input int n, input logic k);
        logic c;
        repeat (n) begin
            @(posedge clk);
            c = 1'($urandom);
            drive(c, c ? 3'($urandom) : 3'h7, k, BA_W'($urandom),
                  ADDR_W'($urandom));
        end
        @(negedge clk);
    endtask : idle
endmodule : dcd_ctrl_model

// ---- tb/sdram_cke_and_command_decode_tb_top.sv ----
// Self-checking bench of the command decoder
`timescale 1ns/100ps
module sdram_cke_and_command_decode_tb_top;
    import dcd_pkg::*;
    localparam int CKE_MIN = 4;

    logic               clk = 1'b0;
    logic               reset = 1'b1;
    logic               cke, cs_n, ras_n, cas_n, we_n;
    logic [BA_W-1:0]    ba;
    logic [ADDR_W-1:0]  addr;
    logic               mr_otf_en = 1'b0;
    logic               mr_fixed_bc4 = 1'b0;
    logic               init_done = 1'b0;
    logic               rd_ready = 1'b0;
    logic               hold = 1'b0;
    logic               rd_valid, rd_len8, rd_auto_close;
    logic [BA_W-1:0]    rd_bank;
    logic [COL_W-1:0]   rd_col;
    dcd_pstate_t        pwr_state;
    logic [BANKS-1:0]   bank_open;
    logic               fully_idle, burst_busy, zq_busy;
    logic               zq_update, cmd_ignored;
    logic [RDQ_W-1:0]   exp_q[$];
    int                 n_fail = 0;
    int                 cmp_count = 0;
    int                 ign_cnt = 0;
    int                 upd_cnt = 0;
    int                 zq_cyc = 0;
    int                 i0;

    always #2.5 clk = ~clk;

    dcd_ctrl_model dcd_ctrl_model_i (.clk(clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

    dcd_cmd_decode dcd_cmd_decode_i (.clk(clk), .reset(reset), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .mr_otf_en(mr_otf_en), .mr_fixed_bc4(mr_fixed_bc4),
        .init_done(init_done), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_bank(rd_bank), .rd_col(rd_col), .rd_len8(rd_len8),
        .rd_auto_close(rd_auto_close), .pwr_state(pwr_state),
        .bank_open(bank_open), .fully_idle(fully_idle),
        .burst_busy(burst_busy), .zq_busy(zq_busy), .zq_update(zq_update),
        .cmd_ignored(cmd_ignored));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk

    task automatic end_of_test;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Random stalls on the read stream unless held off
    always @(posedge clk) rd_ready <= hold ? 1'b0 : 1'($urandom);

    always @(posedge clk) begin
        if (cmd_ignored === 1'b1) ign_cnt++;
        if (zq_update === 1'b1) upd_cnt++;
        if (zq_busy === 1'b1) zq_cyc++;
    end

    // Oldest noted read against each accepted stream entry
    always @(posedge clk) begin
        if (!reset && rd_valid === 1'b1 && rd_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "unexpected read");
            end else begin
                chk({rd_bank, rd_col, rd_len8, rd_auto_close} ===
                    exp_q.pop_front(), "read fields");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic rd(input logic [2:0] b, input logic a12,
                      input logic a10, input logic take);
        logic [ADDR_W-1:0] a;
        a = {3'h0, a12, 1'b0, a10, 10'($urandom)};
        if (take) begin
            exp_q.push_back({b, a[9:0], mr_otf_en ? a12 : !mr_fixed_bc4,
                             a10});
        end
        dcd_ctrl_model_i.send(3'h5, 1'b1, b, a);
    endtask : rd

    task automatic zq(input logic [15:0] a, input int n_exp);
        int z0;
        int u0;
        z0 = zq_cyc;
        u0 = upd_cnt;
        dcd_ctrl_model_i.send(3'h6, 1'b1, 3'h0, a);
        for (int k = 0; k < 700 && (k < 8 || zq_busy === 1'b1); k++)
            @(negedge clk);
        dcd_ctrl_model_i.idle(3, 1'b1);
        chk(zq_cyc - z0 == n_exp, "calibration length");
        chk(upd_cnt == u0 + 1, "calibration update");
    endtask : zq

    task automatic sleep(input logic [2:0] rcw, input dcd_pstate_t s);
        dcd_ctrl_model_i.send(rcw, 1'b0, 3'h0, 16'h0000);
        dcd_ctrl_model_i.idle(CKE_MIN, 1'b0);
        chk(pwr_state === s, "power state entry");
        dcd_ctrl_model_i.idle(8, 1'b0);
        chk(pwr_state === s, "power state held");
        dcd_ctrl_model_i.send(3'h7, 1'b1, 3'h0, 16'h0000);
        dcd_ctrl_model_i.idle(CKE_MIN + 2, 1'b1);
        chk(pwr_state === PS_ON, "power state exit");
    endtask : sleep

    task automatic drain;
        for (int k = 0; k < 60 && exp_q.size() != 0; k++) @(negedge clk);
        dcd_ctrl_model_i.idle(3, 1'b1);
        chk(exp_q.size() == 0 && rd_valid === 1'b0, "read lost");
    endtask : drain

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(63253));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        dcd_ctrl_model_i.idle(CKE_MIN, 1'b1);
        zq(16'h0400, 512);
        @(posedge clk);
        init_done <= 1'b1;
        zq(16'h0400, 256);
        zq(16'h0000, 64);
        // Both per-command burst lengths, a random fixed mode and both close options, one bank each
        for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            mr_otf_en <= j[2];
            mr_fixed_bc4 <= 1'($urandom);
            dcd_ctrl_model_i.send(3'h3, 1'b1, j[2:0], 16'($urandom));
            dcd_ctrl_model_i.idle(6, 1'b1);
            chk(bank_open[j] === 1'b1, "row not opened");
            rd(j[2:0], j[1], j[0], 1'b1);
            dcd_ctrl_model_i.idle(10, 1'b1);
            chk(bank_open[j] === !j[0], "auto close");
        end
        // Write is not handled; refresh with banks open is refused
        i0 = ign_cnt;
        dcd_ctrl_model_i.send(3'h4, 1'b1, 3'h0, 16'h0000);
        dcd_ctrl_model_i.send(3'h1, 1'b1, 3'h0, 16'h0000);
        dcd_ctrl_model_i.idle(6, 1'b1);
        chk(ign_cnt == i0 + 2, "write or refresh acted");
        i0 = ign_cnt;
        rd(3'h1, 1'b1, 1'b0, 1'b0);
        dcd_ctrl_model_i.idle(6, 1'b1);
        chk(ign_cnt == i0 + 1, "read to closed bank");
        @(posedge clk);
        dcd_ctrl_model_i.drive(1'b1, 3'h5, 1'b1, 3'h0, 16'h0000);
        dcd_ctrl_model_i.idle(6, 1'b1);
        chk(burst_busy === 1'b0 && ign_cnt == i0 + 1,
            "deselect acted");
        // Second read inside the first burst is refused
        rd(3'h0, 1'b1, 1'b0, 1'b1);
        rd(3'h2, 1'b1, 1'b0, 1'b0);
        dcd_ctrl_model_i.idle(8, 1'b1);
        chk(ign_cnt == i0 + 2, "burst cut short");
        drain();
        hold <= 1'b1;
        for (int j = 0; j < 3; j++) begin
            rd(3'h0, 1'b0, 1'b0, j < 2);
            dcd_ctrl_model_i.idle(6, 1'b1);
        end
        chk(ign_cnt == i0 + 3 && rd_valid === 1'b1, "buffer full");
        hold <= 1'b0;
        drain();
        sleep(3'h7, PS_PD_ACT);
        rd(3'h0, 1'b1, 1'b0, 1'b1);
        sleep(3'h7, PS_PD);
        drain();
        // Close every bank before any later activation
        dcd_ctrl_model_i.send(3'h2, 1'b1, 3'h0, 16'h0400);
        dcd_ctrl_model_i.idle(8, 1'b1);
        chk(bank_open === 8'h00 && fully_idle === 1'b1, "not idle");
        // Power-down entered while refreshing is the precharge kind
        dcd_ctrl_model_i.send(3'h1, 1'b1, 3'h0, 16'h0000);
        dcd_ctrl_model_i.idle(3, 1'b1);
        chk(fully_idle === 1'b0, "refresh not busy");
        sleep(3'h7, PS_PD_PRE);
        dcd_ctrl_model_i.idle(16, 1'b1);
        chk(fully_idle === 1'b1, "idle after exit");
        sleep(3'h1, PS_SREF);
        end_of_test();
    end
endmodule : sdram_cke_and_command_decode_tb_top
